// ===== hmd_map.svh
// Register offsets, reset values and field positions of the mailbox and doorbell unit.
// Assumes both access ports decode the same word offsets.
`ifndef HMD_MAP_SVH
`define HMD_MAP_SVH

`define HMD_OFF_MSG0        6'h00
`define HMD_OFF_MSG1        6'h01
`define HMD_OFF_MSG2        6'h02
`define HMD_OFF_MSG3        6'h03
`define HMD_OFF_NOTIFY      6'h04
`define HMD_OFF_PRESET      6'h05
`define HMD_OFF_HOST_MASK   6'h06
`define HMD_OFF_CORE_MASK   6'h07
`define HMD_OFF_UNIT_CTRL   6'h08
`define HMD_OFF_OUT_POST    6'h09
`define HMD_OFF_OUT_MASK    6'h0a

`define HMD_INIT_DONE_BIT   0
`define HMD_RST_WORD        32'h0000_0000

`endif

// ===== hmd_pkg.sv
// Types shared by the mailbox and doorbell unit.
// Assumes the map header is included by the design files that need offsets.
package hmd_pkg;
  typedef logic [31:0] hmd_word_t;
  typedef logic [3:0]  hmd_be_t;
  typedef logic [5:0]  hmd_addr_t;
endpackage

// ===== hmd_byte_reg.sv
// One 32-bit register with per-byte write enables.
// Assumes its write strobe and data come from the same clock domain.
`timescale 1ns/1ps
module hmd_byte_reg
  import hmd_pkg::*;
#(
  parameter hmd_word_t RESET_VALUE = 32'h0000_0000
)(
  input  wire logic      i_clock,
  input  wire logic      i_rst_n,
  input  wire logic [3:0] i_be,
  input  wire hmd_word_t  i_data,
  output      hmd_word_t  o_value
);

  hmd_word_t value_q;

  // Each enabled byte lane takes the new byte.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      value_q <= RESET_VALUE;
    end
    else
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (i_be[b])
        begin
          value_q[8*b +: 8] <= i_data[8*b +: 8];
        end
      end
    end
  end

  assign o_value = value_q;

endmodule

// ===== hmd_mailbox.sv
// Mailbox and doorbell unit between the embedded core and a host on the bus.
// Assumes core and host ports are single-cycle register ports on i_clock.
//
// Overview of operation
// - Four 32-bit message registers, byte-writable from core and host.
// - Message contents are stored only, never used by other logic.
// - Notification register holds 32 independent set/reset bits.
// - Core writing 1 sets a bit; host writing 1 clears it; 0 does nothing.
// - Each interrupt is the notification bits, inverted for the core, gated by its mask, ORed.
// - Core-routed bits interrupt when 0; host-routed bits interrupt when 1.
// - Bits with both masks clear cause no interrupt.
// - Writing the preset alias loads the bits directly, from either side.
// - Reading notification register returns all bits to either side.
// - Host pin asserts for notification interrupt or nonempty outbound post list.
// - Post-list part active when post count nonzero unless masked.
// - Host accesses are refused until core sets initialise-complete bit 0.
`timescale 1ns/1ps
`include "hmd_map.svh"
module hmd_mailbox
  import hmd_pkg::*;
#(
  parameter int NUM_MSG = 4,
  parameter int CNT_W   = 16
)(
  input  wire logic      i_clock,
  input  wire logic      i_rst_n,
  input  wire logic      i_core_wr,
  input  wire logic      i_core_rd,
  input  wire hmd_addr_t i_core_addr,
  input  wire hmd_be_t   i_core_be,
  input  wire hmd_word_t i_core_wdata,
  output      hmd_word_t o_core_rdata,
  input  wire logic      i_host_wr,
  input  wire logic      i_host_rd,
  input  wire hmd_addr_t i_host_addr,
  input  wire hmd_be_t   i_host_be,
  input  wire hmd_word_t i_host_wdata,
  output      hmd_word_t o_host_rdata,
  output      logic      o_host_ack,
  output      logic      o_core_irq,
  output      logic      o_host_irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_meta_q;
  logic rst_sync_q;

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access qualification.

  logic unit_init_q;
  logic host_wr_ok;
  logic host_rd_ok;

  assign host_wr_ok = i_host_wr & unit_init_q;
  assign host_rd_ok = i_host_rd & unit_init_q;

  // Full-word write helper: a 32-bit mask of the enabled byte lanes.
  function automatic hmd_word_t lane_mask(input hmd_be_t be);
    hmd_word_t m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[8*b +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  hmd_word_t core_lanes;
  hmd_word_t host_lanes;

  assign core_lanes = lane_mask(i_core_be);
  assign host_lanes = lane_mask(i_host_be);

  ////////////////////////////////////////////////////////////////////////////
  // Message registers.

  hmd_word_t msg_value [NUM_MSG];

  for (genvar g = 0; g < NUM_MSG; g++)
  begin : g_msg
    logic    core_hit;
    logic    host_hit;
    hmd_be_t be_sel;
    hmd_word_t data_sel;
    assign core_hit = i_core_wr && (i_core_addr == (`HMD_OFF_MSG0 + 6'(g)));
    assign host_hit = host_wr_ok && (i_host_addr == (`HMD_OFF_MSG0 + 6'(g)));
    // The core write wins a same-cycle clash on one message register.
    assign be_sel   = core_hit ? i_core_be : (host_hit ? i_host_be : 4'h0);
    assign data_sel = core_hit ? i_core_wdata : i_host_wdata;
    hmd_byte_reg #(
      .RESET_VALUE (`HMD_RST_WORD)
    ) u_msg (
      .i_clock (i_clock),
      .i_rst_n (rst_sync_q),
      .i_be    (be_sel),
      .i_data  (data_sel),
      .o_value (msg_value[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Notification bits.

  hmd_word_t notify_q;
  hmd_word_t notify_d;
  logic      core_set_hit;
  logic      host_clr_hit;
  logic      core_pre_hit;
  logic      host_pre_hit;

  assign core_set_hit = i_core_wr && (i_core_addr == `HMD_OFF_NOTIFY);
  assign host_clr_hit = host_wr_ok && (i_host_addr == `HMD_OFF_NOTIFY);
  assign core_pre_hit = i_core_wr && (i_core_addr == `HMD_OFF_PRESET);
  assign host_pre_hit = host_wr_ok && (i_host_addr == `HMD_OFF_PRESET);

  // Next state of the set/reset bits, later actions taking priority.
  always_comb
  begin
    notify_d = notify_q;
    if (core_pre_hit)
    begin
      notify_d = (notify_d & ~core_lanes) | (i_core_wdata & core_lanes);
    end
    if (host_pre_hit)
    begin
      notify_d = (notify_d & ~host_lanes) | (i_host_wdata & host_lanes);
    end
    if (core_set_hit)
    begin
      notify_d = notify_d | (i_core_wdata & core_lanes);
    end
    if (host_clr_hit)
    begin
      notify_d = notify_d & ~(i_host_wdata & host_lanes);
    end
  end

  always_ff @(posedge i_clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      notify_q <= `HMD_RST_WORD;
    end
    else
    begin
      notify_q <= notify_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Masks, control and outbound post count.

  hmd_word_t host_mask_q;
  hmd_word_t core_mask_q;
  hmd_word_t out_mask_q;
  logic [CNT_W-1:0] out_post_q;

  always_ff @(posedge i_clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      host_mask_q <= `HMD_RST_WORD;
      core_mask_q <= `HMD_RST_WORD;
      out_mask_q  <= `HMD_RST_WORD;
    end
    else
    begin
      if (host_wr_ok && i_host_addr == `HMD_OFF_HOST_MASK)
      begin
        host_mask_q <= (host_mask_q & ~host_lanes) | (i_host_wdata & host_lanes);
      end
      else if (i_core_wr && i_core_addr == `HMD_OFF_HOST_MASK)
      begin
        host_mask_q <= (host_mask_q & ~core_lanes) | (i_core_wdata & core_lanes);
      end
      if (host_wr_ok && i_host_addr == `HMD_OFF_CORE_MASK)
      begin
        core_mask_q <= (core_mask_q & ~host_lanes) | (i_host_wdata & host_lanes);
      end
      else if (i_core_wr && i_core_addr == `HMD_OFF_CORE_MASK)
      begin
        core_mask_q <= (core_mask_q & ~core_lanes) | (i_core_wdata & core_lanes);
      end
      if (i_core_wr && i_core_addr == `HMD_OFF_OUT_MASK)
      begin
        out_mask_q <= (out_mask_q & ~core_lanes) | (i_core_wdata & core_lanes);
      end
    end
  end

  // initialise-complete bit, written by the core only.
  always_ff @(posedge i_clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      unit_init_q <= 1'b0;
    end
    else if (i_core_wr && i_core_addr == `HMD_OFF_UNIT_CTRL && i_core_be[0])
    begin
      unit_init_q <= i_core_wdata[`HMD_INIT_DONE_BIT];
    end
  end

  // Outbound post count: core loads it, each host read of a nonzero count takes one off unless a core load falls in the same cycle.
  always_ff @(posedge i_clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      out_post_q <= '0;
    end
    else if (i_core_wr && i_core_addr == `HMD_OFF_OUT_POST)
    begin
      out_post_q <= i_core_wdata[CNT_W-1:0];
    end
    else if (host_rd_ok && i_host_addr == `HMD_OFF_OUT_POST && out_post_q != '0)
    begin
      out_post_q <= out_post_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  logic core_irq_d;
  logic host_db_irq;
  logic post_irq;

  // core on 0, host on 1
  // both masks set makes both terms possible; software keeps them apart
  assign core_irq_d  = |(~notify_q & core_mask_q);
  assign host_db_irq = |(notify_q & host_mask_q);
  assign post_irq    = (out_post_q != '0) && !out_mask_q[0];

  always_ff @(posedge i_clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      o_core_irq   <= 1'b0;
      o_host_irq_n <= 1'b1;
    end
    else
    begin
      o_core_irq   <= core_irq_d;
      o_host_irq_n <= ~(host_db_irq | post_irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  function automatic hmd_word_t read_word(input hmd_addr_t a);
    hmd_word_t r;
    r = '0;
    unique case (a)
      `HMD_OFF_MSG0:      r = msg_value[0];
      `HMD_OFF_MSG1:      r = msg_value[1];
      `HMD_OFF_MSG2:      r = msg_value[2];
      `HMD_OFF_MSG3:      r = msg_value[3];
      `HMD_OFF_NOTIFY:    r = notify_q;
      `HMD_OFF_PRESET:    r = notify_q;
      `HMD_OFF_HOST_MASK: r = host_mask_q;
      `HMD_OFF_CORE_MASK: r = core_mask_q;
      `HMD_OFF_UNIT_CTRL: r = {31'h0, unit_init_q};
      `HMD_OFF_OUT_POST:  r = 32'(out_post_q);
      `HMD_OFF_OUT_MASK:  r = out_mask_q;
      default:            r = '0;
    endcase
    return r;
  endfunction

  // Read data registered one cycle after the strobe; refused host reads give zero.
  always_ff @(posedge i_clock or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      o_core_rdata <= '0;
      o_host_rdata <= '0;
      o_host_ack   <= 1'b0;
    end
    else
    begin
      o_core_rdata <= i_core_rd ? read_word(i_core_addr) : '0;
      o_host_rdata <= host_rd_ok ? read_word(i_host_addr) : '0;
      o_host_ack   <= host_wr_ok | host_rd_ok;
    end
  end

endmodule

// ===== hmd_host_model.sv
// Host-side bus model that makes register accesses to the mailbox unit.
// Assumes every task is entered just after a falling clock edge.
`timescale 1ns/1ps
module hmd_host_model
  import hmd_pkg::*;
(
  input  wire logic      i_clock,
  input  wire hmd_word_t i_rdata,
  input  wire logic      i_ack,
  output      logic      o_wr,
  output      logic      o_rd,
  output      hmd_addr_t o_addr,
  output      hmd_be_t   o_be,
  output      hmd_word_t o_wdata
);
  // The bus starts idle with no strobe raised.
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h3f;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end

  // One write; released address and data lines show the inverse of what they carried.
  // A quiet cycle follows, so a strobe never drops and rises in one time step.
  task automatic hwr(input hmd_addr_t ad, input hmd_be_t be, input hmd_word_t d);
    o_wr = 1'b1;
    o_addr = ad;
    o_be = be;
    o_wdata = d;
    @(negedge i_clock);
    o_wr = 1'b0;
    o_addr = ~ad;
    o_wdata = ~d;
    @(negedge i_clock);
  endtask

  // One read; data and acknowledge are taken one cycle after the request.
  task automatic hrd(input hmd_addr_t ad, output hmd_word_t d, output logic ack);
    o_rd = 1'b1;
    o_addr = ad;
    @(negedge i_clock);
    d = i_rdata;
    ack = i_ack;
    o_rd = 1'b0;
    o_addr = ~ad;
    @(negedge i_clock);
  endtask
endmodule

// ===== hmd_mailbox_props.sv
// Concurrent checks on the ports of the mailbox and doorbell unit.
// Assumes one clock and the word offsets of the map header.
`timescale 1ns/1ps
`include "hmd_map.svh"
module hmd_mailbox_props
  import hmd_pkg::*;
#(
  parameter int NUM_MSG = 4,
  parameter int CNT_W   = 16
)(
  input wire logic      i_clock,
  input wire logic      i_rst_n,
  input wire logic      i_core_wr,
  input wire logic      i_core_rd,
  input wire hmd_addr_t i_core_addr,
  input wire hmd_be_t   i_core_be,
  input wire hmd_word_t i_core_wdata,
  input wire hmd_word_t o_core_rdata,
  input wire logic      i_host_wr,
  input wire logic      i_host_rd,
  input wire hmd_addr_t i_host_addr,
  input wire hmd_be_t   i_host_be,
  input wire hmd_word_t i_host_wdata,
  input wire hmd_word_t o_host_rdata,
  input wire logic      o_host_ack,
  input wire logic      o_core_irq,
  input wire logic      o_host_irq_n
);
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////
  // Full-word writes and reads at one offset; the core sequences require no host write.
  // Drivers leave one quiet cycle after each access, so a read trails its write by two.
  sequence s_cw(a);
    i_core_wr && i_core_addr == a && i_core_be == 4'hf && !i_host_wr;
  endsequence
  sequence s_cr(a);
    i_core_rd && i_core_addr == a && !i_host_wr;
  endsequence
  sequence s_hw(a);
    i_host_wr && i_host_addr == a && i_host_be == 4'hf;
  endsequence

  AST_CORE_RD_IDLE: assert property (!i_core_rd |=> o_core_rdata == 32'h0)
    else $error("core read data not idle");
  AST_HOST_RD_IDLE: assert property (!o_host_ack |-> o_host_rdata == 32'h0)
    else $error("host read data without access");
  AST_ACK_CAUSE: assert property (o_host_ack |-> $past(i_host_wr) || $past(i_host_rd))
    else $error("host ack without request");
  AST_MSG_ECHO: assert property (s_cw(`HMD_OFF_MSG1) ##2 s_cr(`HMD_OFF_MSG1)
    |=> o_core_rdata == $past(i_core_wdata, 3)) else $error("message not kept");
  AST_CORE_SET: assert property (s_cw(`HMD_OFF_NOTIFY) ##2 s_cr(`HMD_OFF_NOTIFY)
    |=> (o_core_rdata & $past(i_core_wdata, 3)) == $past(i_core_wdata, 3))
    else $error("core write did not set");
  AST_HOST_CLR: assert property (s_hw(`HMD_OFF_NOTIFY) ##1 o_host_ack
    ##1 s_cr(`HMD_OFF_NOTIFY) |=> (o_core_rdata & $past(i_host_wdata, 3)) == 32'h0)
    else $error("host write did not clear");
  AST_PRESET: assert property (s_cw(`HMD_OFF_PRESET) ##2 s_cr(`HMD_OFF_NOTIFY)
    |=> o_core_rdata == $past(i_core_wdata, 3)) else $error("preset not loaded");
  AST_MASK_RW: assert property (s_cw(`HMD_OFF_HOST_MASK) ##2 s_cr(`HMD_OFF_HOST_MASK)
    |=> o_core_rdata == $past(i_core_wdata, 3)) else $error("mask not kept");
  AST_CORE_IRQ_OFF: assert property (s_cw(`HMD_OFF_PRESET) ##0 i_core_wdata == 32'hffff_ffff
    |-> ##2 !o_core_irq) else $error("core irq with all bits set");
endmodule

bind hmd_mailbox hmd_mailbox_props #(.NUM_MSG(NUM_MSG), .CNT_W(CNT_W)) u_props (
  .i_clock, .i_rst_n, .i_core_wr, .i_core_rd, .i_core_addr, .i_core_be,
  .i_core_wdata, .o_core_rdata, .i_host_wr, .i_host_rd, .i_host_addr, .i_host_be,
  .i_host_wdata, .o_host_rdata, .o_host_ack, .o_core_irq, .o_host_irq_n
);

// ===== test_host_cpu_mailbox_doorbell.sv
// Self-checking bench for the mailbox and doorbell unit.
// Assumes the host model drives the host port; inputs change at falling edges.
`timescale 1ns/1ps
`include "hmd_map.svh"
module test_host_cpu_mailbox_doorbell
  import hmd_pkg::*;
;
  logic      i_clock = 1'b0, i_rst_n = 1'b0, i_core_wr = 1'b0, i_core_rd = 1'b0;
  hmd_addr_t i_core_addr = 6'h00, i_host_addr;
  hmd_be_t   i_core_be = 4'h0, i_host_be;
  hmd_word_t i_core_wdata = 32'h0, i_host_wdata, o_core_rdata, o_host_rdata, v;
  logic      i_host_wr, i_host_rd, o_host_ack, o_core_irq, o_host_irq_n, a;
  int        fail_count = 0;
  int        checked = 0;

  always #12.5 i_clock = ~i_clock;

  hmd_mailbox uut (.i_clock, .i_rst_n, .i_core_wr, .i_core_rd, .i_core_addr, .i_core_be,
    .i_core_wdata, .o_core_rdata, .i_host_wr, .i_host_rd, .i_host_addr, .i_host_be,
    .i_host_wdata, .o_host_rdata, .o_host_ack, .o_core_irq, .o_host_irq_n);
  hmd_host_model u_host (.i_clock, .i_rdata(o_host_rdata), .i_ack(o_host_ack),
    .o_wr(i_host_wr), .o_rd(i_host_rd), .o_addr(i_host_addr), .o_be(i_host_be),
    .o_wdata(i_host_wdata));

  ////////////////////////////////////////
  // Compare, count and report.
  task automatic chk(input string what, input hmd_word_t exp, input hmd_word_t got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic irq(input logic c, input logic h);
    chk("core_irq", {31'h0, c}, {31'h0, o_core_irq});
    chk("host_irq_n", {31'h0, h}, {31'h0, o_host_irq_n});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // Core port accesses: one strobe cycle, then one quiet cycle between accesses.
  task automatic cwr(input hmd_addr_t ad, input hmd_be_t be, input hmd_word_t d);
    i_core_wr = 1'b1;
    i_core_addr = ad;
    i_core_be = be;
    i_core_wdata = d;
    @(negedge i_clock);
    i_core_wr = 1'b0;
    @(negedge i_clock);
  endtask
  task automatic crd(input hmd_addr_t ad, input hmd_word_t exp);
    i_core_rd = 1'b1;
    i_core_addr = ad;
    @(negedge i_clock);
    i_core_rd = 1'b0;
    chk("core_rdata", exp, o_core_rdata);
    @(negedge i_clock);
  endtask
  task automatic hchk(input hmd_addr_t ad, input hmd_word_t exp, input logic ack);
    u_host.hrd(ad, v, a);
    chk("host_ack", {31'h0, ack}, {31'h0, a});
    chk("host_rdata", exp, v);
  endtask

  ////////////////////////////////////////
  // Host refused until the core sets the init bit.
  task automatic t_refuse();
    cwr(`HMD_OFF_MSG0, 4'hf, 32'h5a5a_5a5a);
    hchk(`HMD_OFF_MSG0, 32'h0, 1'b0);
    cwr(`HMD_OFF_UNIT_CTRL, 4'hf, 32'h1);
    hchk(`HMD_OFF_MSG0, 32'h5a5a_5a5a, 1'b1);
  endtask
  // Init order: preset, host mask, then core mask, disjoint.
  task automatic t_init();
    cwr(`HMD_OFF_PRESET, 4'hf, 32'h0000_ff00);
    cwr(`HMD_OFF_HOST_MASK, 4'hf, 32'h0000_00ff);
    crd(`HMD_OFF_HOST_MASK, 32'h0000_00ff);
    cwr(`HMD_OFF_CORE_MASK, 4'hf, 32'h0000_ff00);
    hchk(`HMD_OFF_CORE_MASK, 32'h0000_ff00, 1'b1);
    irq(1'b0, 1'b1);
  endtask
  // Set, clear, no-effect zero and interrupts both ways.
  task automatic t_doorbell();
    cwr(`HMD_OFF_NOTIFY, 4'hf, 32'h1);
    crd(`HMD_OFF_NOTIFY, 32'h0000_ff01);
    irq(1'b0, 1'b0);
    hchk(`HMD_OFF_NOTIFY, 32'h0000_ff01, 1'b1);
    u_host.hwr(`HMD_OFF_NOTIFY, 4'hf, 32'h0000_0101);
    crd(`HMD_OFF_NOTIFY, 32'h0000_fe00);
    irq(1'b1, 1'b1);
    cwr(`HMD_OFF_NOTIFY, 4'hf, 32'h0);
    crd(`HMD_OFF_NOTIFY, 32'h0000_fe00);
    cwr(`HMD_OFF_NOTIFY, 4'h2, 32'h0000_0100);
    idle(1);
    irq(1'b0, 1'b1);
  endtask
  // Preset from both sides; an unrouted bit stays silent.
  task automatic t_preset();
    cwr(`HMD_OFF_PRESET, 4'hf, 32'hffff_ffff);
    crd(`HMD_OFF_NOTIFY, 32'hffff_ffff);
    irq(1'b0, 1'b0);
    u_host.hwr(`HMD_OFF_PRESET, 4'hf, 32'h0001_ff00);
    idle(1);
    irq(1'b0, 1'b1);
    u_host.hwr(`HMD_OFF_PRESET, 4'hf, 32'h0000_fe01);
    idle(1);
    irq(1'b1, 1'b0);
    cwr(`HMD_OFF_PRESET, 4'hf, 32'h0000_ff00);
  endtask
  // Core set and host clear of one bit in the same cycle.
  task automatic t_race();
    fork
      cwr(`HMD_OFF_NOTIFY, 4'hf, 32'h1);
      u_host.hwr(`HMD_OFF_NOTIFY, 4'hf, 32'h1);
    join
    crd(`HMD_OFF_NOTIFY, 32'h0000_ff00);
  endtask
  // All four messages, then byte lanes from the host.
  task automatic t_msg();
    for (int i = 0; i < 4; i++)
      cwr(hmd_addr_t'(i), 4'hf, 32'h1111_1111 * (i + 1));
    for (int i = 0; i < 4; i++)
      hchk(hmd_addr_t'(i), 32'h1111_1111 * (i + 1), 1'b1);
    cwr(`HMD_OFF_MSG1, 4'hf, 32'h1122_3344);
    crd(`HMD_OFF_MSG1, 32'h1122_3344);
    u_host.hwr(`HMD_OFF_MSG1, 4'ha, 32'haabb_ccdd);
    crd(`HMD_OFF_MSG1, 32'haa22_cc44);
    irq(1'b0, 1'b1);
    hchk(6'h3f, 32'h0, 1'b1);
  endtask
  // Outbound post count drives the host pin unless masked.
  task automatic t_post();
    cwr(`HMD_OFF_OUT_POST, 4'hf, 32'h2);
    idle(1);
    irq(1'b0, 1'b0);
    hchk(`HMD_OFF_OUT_POST, 32'h2, 1'b1);
    hchk(`HMD_OFF_OUT_POST, 32'h1, 1'b1);
    idle(1);
    irq(1'b0, 1'b1);
    cwr(`HMD_OFF_OUT_POST, 4'hf, 32'h1);
    cwr(`HMD_OFF_OUT_MASK, 4'hf, 32'h1);
    idle(1);
    irq(1'b0, 1'b1);
    cwr(`HMD_OFF_OUT_MASK, 4'hf, 32'h0);
    idle(1);
    irq(1'b0, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Reset, then every scenario in turn.
  initial
  begin
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'b1;
    idle(3);
    t_refuse();
    t_init();
    t_doorbell();
    t_preset();
    t_race();
    t_msg();
    t_post();
    tally_and_finish();
  end
  // Cut a hang short after far more cycles than the run needs.
  initial
  begin
    #75000;
    fail_count++;
    tally_and_finish();
  end
endmodule
